/* src/nic_regs_pkg.sv */
// register map, field positions and reset values of the network controller register bank
package nic_regs_pkg;

    localparam int REG_ADDR_W = 6;
    localparam int DATA_W     = 16;

    localparam logic [5:0] OFS_COMMAND     = 6'h00;
    localparam logic [5:0] OFS_DATA_CFG    = 6'h01;
    localparam logic [5:0] OFS_RX_CTRL     = 6'h02;
    localparam logic [5:0] OFS_TX_CTRL     = 6'h03;
    localparam logic [5:0] OFS_INT_MASK    = 6'h04;
    localparam logic [5:0] OFS_INT_STATUS  = 6'h05;
    localparam logic [5:0] OFS_TX_UPPER    = 6'h06;
    localparam logic [5:0] OFS_TX_CURRENT  = 6'h07;
    localparam logic [5:0] OFS_RXD_UPPER   = 6'h0d;
    localparam logic [5:0] OFS_RXD_CURRENT = 6'h0e;
    localparam logic [5:0] OFS_RES_UPPER   = 6'h14;
    localparam logic [5:0] OFS_RES_START   = 6'h15;
    localparam logic [5:0] OFS_RES_END     = 6'h16;
    localparam logic [5:0] OFS_RES_READ    = 6'h17;
    localparam logic [5:0] OFS_RES_WRITE   = 6'h18;
    localparam logic [5:0] OFS_ENTRY_SEL   = 6'h21;
    localparam logic [5:0] OFS_PORT_HIGH   = 6'h22;
    localparam logic [5:0] OFS_PORT_MID    = 6'h23;
    localparam logic [5:0] OFS_PORT_LOW    = 6'h24;
    localparam logic [5:0] OFS_ENTRY_EN    = 6'h25;
    localparam logic [5:0] OFS_DESC_PTR    = 6'h26;
    localparam logic [5:0] OFS_DESC_COUNT  = 6'h27;
    localparam logic [5:0] OFS_REVISION    = 6'h28;
    localparam logic [5:0] OFS_TIMER_LOW   = 6'h29;
    localparam logic [5:0] OFS_TIMER_HIGH  = 6'h2a;
    localparam logic [5:0] OFS_RX_SEQ      = 6'h2b;
    localparam logic [5:0] OFS_CRC_TALLY   = 6'h2c;
    localparam logic [5:0] OFS_ALIGN_TALLY = 6'h2d;
    localparam logic [5:0] OFS_MISS_TALLY  = 6'h2e;
    localparam logic [5:0] OFS_DATA_CFG2   = 6'h3f;

    // field positions
    localparam int CMD_SOFT_RESET_BIT  = 7;
    localparam int CMD_LOAD_FILTER_BIT = 9;
    localparam int ISR_LOAD_DONE_BIT   = 12;
    localparam int DCR_WIDE_BUS_BIT    = 5;
    localparam int DATA_CONFIG_SECOND_FULL_DUPLEX_BIT = 5;
    localparam int DATA_CONFIG_SECOND_HEARTBEAT_BIT  = 11;
    localparam int DESC_COUNT_BITS     = 5;

    // reset values
    localparam logic [15:0] COMMAND_RESET = 16'h0080;
    localparam logic [15:0] REG_RESET     = 16'h0000;
    localparam logic [15:0] ENTRY_EN_RESET = 16'h0000;
    localparam logic [15:0] REVISION_DEFAULT = 16'h0001;  // arbitrary value

    // byte step of the descriptor pointer per fetched field
    localparam logic [15:0] STEP_NARROW = 16'h0002;
    localparam logic [15:0] STEP_WIDE   = 16'h0004;

    typedef enum logic [2:0] {
        ld_idle,
        ld_wait,
        ld_fetch,
        ld_write,
        ld_mask,
        ld_done
    } loader_state_type;

endpackage

/* src/filter_table_mem.sv */
// address-filter table storage with registered read data
module filter_table_mem #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 48
) (
    input  wire logic                     mclk,
    input  wire logic                     ce,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]         wr_data,
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic      [WIDTH-1:0]         rd_data
);
    logic [WIDTH-1:0] cells [0:DEPTH-1];

    if (DEPTH < 2 || WIDTH < 1) begin : g_check
        $error("filter_table_mem: unsupported geometry");
    end

    always_ff @(posedge mclk) begin
        if (ce && wr_en) begin
            cells[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (ce) begin
            rd_data <= cells[rd_addr];
        end
    end
endmodule // filter_table_mem

/* src/nic_register_map_cam_loader.sv */
// user register bank, filter-table load sequencer and duplex configuration
module nic_register_map_cam_loader #(
    parameter int                          ENTRIES  = 16,
    parameter logic [nic_regs_pkg::DATA_W-1:0] REVISION = nic_regs_pkg::REVISION_DEFAULT
) (
    input  wire logic                                  mclk,
    input  wire logic                                  rst,
    input  wire logic                                  ce,
    input  wire logic                                  chip_sel,
    input  wire logic [nic_regs_pkg::REG_ADDR_W-1:0]   reg_addr_inputs,
    input  wire logic                                  reg_write,
    input  wire logic [nic_regs_pkg::DATA_W-1:0]       reg_wdata,
    output logic      [nic_regs_pkg::DATA_W-1:0]       reg_rdata,
    output logic                                       mem_req,
    output logic      [31:0]                           mem_addr,
    input  wire logic                                  mem_ack,
    input  wire logic [31:0]                           mem_rdata,
    input  wire logic                                  frame_active,
    input  wire logic                                  collision_in,
    output logic                                       collision_out,
    output logic                                       soft_reset,
    output logic                                       full_duplex_enable,
    output logic                                       heartbeat_disable
);
    import nic_regs_pkg::*;

    localparam int SEL_W = $clog2(ENTRIES);

    if (ENTRIES < 2 || ENTRIES > 16) begin : g_check
        $error("nic_register_map_cam_loader: ENTRIES must be 2 to 16");
    end

    logic [15:0]      plain_regs [0:63];
    logic [15:0]      command_reg;
    logic [15:0]      interrupt_status_reg;
    logic [15:0]      filter_entry_select;
    logic [15:0]      filter_entry_enable;
    logic [15:0]      filter_desc_pointer;
    logic [15:0]      filter_desc_count;
    logic [15:0]      slice_low;
    logic [15:0]      slice_mid;
    logic [15:0]      slice_high;
    logic [1:0]       field_idx;
    logic             table_wr;
    logic [47:0]      table_rd;
    loader_state_type state;

    function automatic logic is_plain(input logic [5:0] a);
        return a == OFS_DATA_CFG || a == OFS_RX_CTRL || a == OFS_TX_CTRL || a == OFS_INT_MASK
            || a == OFS_TX_UPPER || a == OFS_TX_CURRENT || a == OFS_RXD_UPPER || a == OFS_RXD_CURRENT
            || a == OFS_RES_UPPER || a == OFS_RES_START || a == OFS_RES_END || a == OFS_RES_READ
            || a == OFS_RES_WRITE || a == OFS_TIMER_LOW || a == OFS_TIMER_HIGH || a == OFS_RX_SEQ
            || a == OFS_CRC_TALLY || a == OFS_ALIGN_TALLY || a == OFS_MISS_TALLY || a == OFS_DATA_CFG2;
    endfunction

    function automatic logic [15:0] ptr_step(input logic wide);
        return wide ? STEP_WIDE : STEP_NARROW;
    endfunction

    wire logic host_wr = chip_sel && reg_write;
    wire logic host_rd = chip_sel && !reg_write;
    wire logic fetch_ack = mem_req && mem_ack;
    wire logic wide_bus = plain_regs[OFS_DATA_CFG][DCR_WIDE_BUS_BIT];
    wire logic [15:0] next_pointer = filter_desc_pointer + ptr_step(wide_bus);
    wire logic [15:0] field_data = mem_rdata[15:0];
    wire logic [15:0] next_count = {11'h000, filter_desc_count[DESC_COUNT_BITS-1:0] - 5'h01};

    // plain storage registers, including the split general timer
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < 64; i++) begin
                plain_regs[i] <= REG_RESET;
            end
        end else if (ce && host_wr && is_plain(reg_addr_inputs)) begin
            plain_regs[reg_addr_inputs] <= reg_wdata;
        end
    end

    assign full_duplex_enable = plain_regs[OFS_DATA_CFG2][DATA_CONFIG_SECOND_FULL_DUPLEX_BIT];
    assign heartbeat_disable  = plain_regs[OFS_DATA_CFG2][DATA_CONFIG_SECOND_HEARTBEAT_BIT];
    assign soft_reset         = command_reg[CMD_SOFT_RESET_BIT];

    // command register; host set of the load bit wins over loader clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            command_reg <= COMMAND_RESET;
        end else if (ce) begin
            if (host_wr && reg_addr_inputs == OFS_COMMAND) begin
                command_reg <= reg_wdata;
                command_reg[CMD_LOAD_FILTER_BIT] <= reg_wdata[CMD_LOAD_FILTER_BIT]
                    || (command_reg[CMD_LOAD_FILTER_BIT] && state != ld_done);
            end else if (state == ld_done) begin
                command_reg[CMD_LOAD_FILTER_BIT] <= 1'b0;
            end
        end
    end

    // interrupt status: write one to clear, hardware set wins
    always_ff @(posedge mclk) begin
        if (rst) begin
            interrupt_status_reg <= REG_RESET;
        end else if (ce) begin
            if (state == ld_done) begin
                interrupt_status_reg[ISR_LOAD_DONE_BIT] <= 1'b1;
            end else if (host_wr && reg_addr_inputs == OFS_INT_STATUS && reg_wdata[ISR_LOAD_DONE_BIT]) begin
                interrupt_status_reg[ISR_LOAD_DONE_BIT] <= 1'b0;
            end
        end
    end

    // load sequencer; owns pointer, count, entry select and enable while busy
    always_ff @(posedge mclk) begin
        if (rst) begin
            state               <= ld_idle;
            mem_req             <= 1'b0;
            field_idx           <= 2'd0;
            filter_entry_select <= REG_RESET;
            filter_entry_enable <= ENTRY_EN_RESET;
            filter_desc_pointer <= REG_RESET;
            filter_desc_count   <= REG_RESET;
            slice_low           <= REG_RESET;
            slice_mid           <= REG_RESET;
            slice_high          <= REG_RESET;
        end else if (ce) begin
            if (state == ld_idle && host_wr) begin
                unique case (reg_addr_inputs)
                    OFS_ENTRY_SEL:  filter_entry_select <= reg_wdata;
                    OFS_ENTRY_EN:   filter_entry_enable <= reg_wdata;
                    OFS_DESC_PTR:   filter_desc_pointer <= reg_wdata;
                    OFS_DESC_COUNT: filter_desc_count   <= reg_wdata;
                    default: ;
                endcase
            end
            unique case (state)
                ld_idle: begin
                    if (command_reg[CMD_LOAD_FILTER_BIT]) begin
                        state <= ld_wait;
                    end
                end
                ld_wait: begin
                    if (!frame_active) begin
                        field_idx <= 2'd0;
                        if (filter_desc_count[DESC_COUNT_BITS-1:0] == 5'h00) begin
                            state <= ld_mask;
                        end else begin
                            state <= ld_fetch;
                        end
                    end
                end
                ld_fetch: begin
                    if (!mem_req) begin
                        mem_req <= 1'b1;
                    end else if (mem_ack) begin
                        mem_req             <= 1'b0;
                        filter_desc_pointer <= next_pointer;
                        field_idx           <= field_idx + 2'd1;
                        unique case (field_idx)
                            2'd0: filter_entry_select <= field_data;
                            2'd1: slice_low <= field_data;
                            2'd2: slice_mid <= field_data;
                            2'd3: slice_high <= field_data;
                        endcase
                        if (field_idx == 2'd3) begin
                            state <= ld_write;
                        end
                    end
                end
                ld_write: begin
                    filter_desc_count <= next_count;
                    if (next_count[DESC_COUNT_BITS-1:0] == 5'h00) begin
                        state <= ld_mask;
                    end else begin
                        state <= ld_fetch;
                    end
                end
                ld_mask: begin
                    if (!mem_req) begin
                        mem_req <= 1'b1;
                    end else if (mem_ack) begin
                        mem_req             <= 1'b0;
                        filter_entry_enable <= field_data;
                        filter_desc_pointer <= next_pointer;
                        filter_desc_count   <= REG_RESET;
                        state               <= ld_done;
                    end
                end
                ld_done: begin
                    state <= ld_idle;
                end
            endcase
        end
    end

    // memory address: upper base joined with the descriptor offset
    always_ff @(posedge mclk) begin
        if (rst) begin
            mem_addr <= 32'h0000_0000;
        end else if (ce) begin
            mem_addr <= {plain_regs[OFS_RES_UPPER], filter_desc_pointer};
        end
    end

    assign table_wr = (state == ld_write);

    filter_table_mem #(
        .DEPTH (ENTRIES),
        .WIDTH (48)
    ) u_table (
        .mclk    (mclk),
        .ce      (ce),
        .wr_en   (table_wr),
        .wr_addr (filter_entry_select[SEL_W-1:0]),
        .wr_data ({slice_high, slice_mid, slice_low}),
        .rd_addr (filter_entry_select[SEL_W-1:0]),
        .rd_data (table_rd)
    );

    // collision indication masked in full duplex
    always_ff @(posedge mclk) begin
        if (rst) begin
            collision_out <= 1'b0;
        end else if (ce) begin
            collision_out <= collision_in && !full_duplex_enable;
        end
    end

    // registered read data; unmapped addresses read zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= REG_RESET;
        end else if (ce && host_rd) begin
            if (is_plain(reg_addr_inputs)) begin
                reg_rdata <= plain_regs[reg_addr_inputs];
            end else begin
                unique case (reg_addr_inputs)
                    OFS_COMMAND:    reg_rdata <= command_reg;
                    OFS_INT_STATUS: reg_rdata <= interrupt_status_reg;
                    OFS_ENTRY_SEL:  reg_rdata <= filter_entry_select;
                    OFS_ENTRY_EN:   reg_rdata <= filter_entry_enable;
                    OFS_DESC_PTR:   reg_rdata <= filter_desc_pointer;
                    OFS_DESC_COUNT: reg_rdata <= filter_desc_count;
                    OFS_REVISION:   reg_rdata <= REVISION;
                    OFS_PORT_HIGH:  reg_rdata <= soft_reset ? table_rd[47:32] : REG_RESET;
                    OFS_PORT_MID:   reg_rdata <= soft_reset ? table_rd[31:16] : REG_RESET;
                    OFS_PORT_LOW:   reg_rdata <= soft_reset ? table_rd[15:0] : REG_RESET;
                    default:        reg_rdata <= REG_RESET;
                endcase
            end
        end
    end

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst || !ce);

    sequence s_field_taken;
        mem_req && mem_ack && (state == ld_fetch || state == ld_mask);
    endsequence

    sequence s_load_finish;
        state == ld_done;
    endsequence

    a_done_flags: assert property (s_load_finish |=> !command_reg[CMD_LOAD_FILTER_BIT] || $past(host_wr))
        else $error("load bit not cleared at finish");
    a_done_status: assert property (s_load_finish |=> interrupt_status_reg[ISR_LOAD_DONE_BIT])
        else $error("load done flag not set");
    a_count_zero: assert property (s_load_finish |-> filter_desc_count[DESC_COUNT_BITS-1:0] == 5'h00)
        else $error("descriptor count not zero after load");
    a_pointer_step: assert property (s_field_taken |=> filter_desc_pointer == $past(next_pointer))
        else $error("descriptor pointer did not advance");
    a_quiet_wait: assert property ((state == ld_wait && frame_active) |=> state == ld_wait && !mem_req)
        else $error("fetch started during frame activity");
    a_addr_upper: assert property (mem_req |-> mem_addr == {plain_regs[OFS_RES_UPPER], filter_desc_pointer})
        else $error("fetch address not formed from base and pointer");
    a_mask_load: assert property ((mem_req && mem_ack && state == ld_mask) |=> filter_entry_enable == $past(mem_rdata[15:0]))
        else $error("enable mask not loaded from last field");
    a_collision_mask: assert property (collision_out |-> !$past(full_duplex_enable))
        else $error("collision passed in full duplex");
    a_port_invalid: assert property ((host_rd && !soft_reset && reg_addr_inputs == OFS_PORT_LOW) |=> reg_rdata == 16'h0000)
        else $error("filter port readable outside reset");
    a_revision_read: assert property ((host_rd && reg_addr_inputs == OFS_REVISION) |=> reg_rdata == REVISION)
        else $error("revision register wrong");
endmodule // nic_register_map_cam_loader

/* dv/mem_model.sv */
// system memory model answering the filter-table loader's fetches
module mem_model (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    input  wire logic [15:0] upper,
    input  wire logic [3:0]  delay,
    output logic             mem_ack,
    output logic      [31:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] words [0:255];
    logic [3:0]  waited;
    task automatic put(input logic [7:0] a, input logic [15:0] v);
        words[a] = v;
    endtask
    // data lines toggle whenever no answer is given
    always_ff @(posedge mclk) begin
        if (rst) begin
            mem_ack   <= 1'b0;
            waited    <= 4'h0;
            mem_rdata <= 32'h5a5a_a5a5;
        end else if (mem_ack || !mem_req) begin
            mem_ack   <= 1'b0;
            waited    <= 4'h0;
            mem_rdata <= ~mem_rdata;
        end else if (waited >= delay && mem_addr[31:16] == upper) begin
            mem_ack   <= 1'b1;
            mem_rdata <= {~words[mem_addr[7:0]], words[mem_addr[7:0]]};
        end else begin
            waited    <= waited + 4'h1;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule // mem_model

/* dv/nic_register_map_cam_loader_bench.sv */
// self-checking bench for the register bank and filter-table loader
module nic_register_map_cam_loader_bench;
    import nic_regs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] REV = 16'h00a7;  // arbitrary value
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        chip_sel = 1'b0;
    logic        reg_write = 1'b0;
    logic [5:0]  reg_addr_inputs = 6'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic        mem_req;
    logic [31:0] mem_addr;
    logic        mem_ack;
    logic [31:0] mem_rdata;
    logic        frame_active = 1'b0;
    logic        collision_in = 1'b0;
    logic        collision_out;
    logic        soft_reset;
    logic        full_duplex_enable;
    logic        heartbeat_disable;
    logic [3:0]  delay = 4'h0;
    int          fail_count = 0;
    int          checked = 0;

    initial forever #10 mclk = ~mclk;

    nic_register_map_cam_loader #(.REVISION(REV)) dut_u (.mclk(mclk), .rst(rst), .ce(ce), .chip_sel(chip_sel),
        .reg_addr_inputs(reg_addr_inputs), .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .frame_active(frame_active), .collision_in(collision_in), .collision_out(collision_out),
        .soft_reset(soft_reset), .full_duplex_enable(full_duplex_enable), .heartbeat_disable(heartbeat_disable));
    mem_model mem_u (.mclk(mclk), .rst(rst), .mem_req(mem_req), .mem_addr(mem_addr), .upper(16'h00c3),
        .delay(delay), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic reg_wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge mclk);
        chip_sel <= 1'b1;
        reg_write <= 1'b1;
        reg_addr_inputs <= a;
        reg_wdata <= d;
        @(posedge mclk);
        chip_sel <= 1'b0;
        reg_write <= 1'b0;
    endtask
    task automatic reg_rd(input logic [5:0] a, output logic [15:0] d);
        @(posedge mclk);
        chip_sel <= 1'b1;
        reg_addr_inputs <= a;
        @(posedge mclk);
        chip_sel <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic rd_cmp(input logic [5:0] a, input logic [15:0] exp, input string what);
        logic [15:0] v;
        reg_rd(a, v);
        cmp(what, exp, v);
    endtask
    function automatic logic [15:0] slice(input logic [15:0] e, input int k);
        return {e[3:0], 4'(k), 8'h3c};
    endfunction

    task automatic t_reset();
        rd_cmp(OFS_COMMAND, COMMAND_RESET, "command");
        cmp("soft_reset", 16'h0001, {15'h0, soft_reset});
        rd_cmp(OFS_REVISION, REV, "revision");
        reg_wr(OFS_REVISION, 16'hffff);
        rd_cmp(OFS_REVISION, REV, "revision kept");
        rd_cmp(6'h30, 16'h0000, "unmapped");
    endtask
    task automatic t_duplex();
        reg_wr(OFS_DATA_CFG2, 16'h0820);
        #1 cmp("full duplex", 16'h0001, {15'h0, full_duplex_enable});
        cmp("heartbeat", 16'h0001, {15'h0, heartbeat_disable});
        @(posedge mclk);
        collision_in <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 cmp("collision fd", 16'h0000, {15'h0, collision_out});
        reg_wr(OFS_DATA_CFG2, 16'h0000);
        repeat (2) @(posedge mclk);
        #1 cmp("collision hd", 16'h0001, {15'h0, collision_out});
        cmp("heartbeat off", 16'h0000, {15'h0, heartbeat_disable});
        @(posedge mclk);
        collision_in <= 1'b0;
        reg_wr(OFS_RES_END, 16'h1000);
        rd_cmp(OFS_RES_END, 16'h1000, "resource end");
        reg_wr(OFS_TIMER_LOW, 16'h1234);
        reg_wr(OFS_TIMER_HIGH, 16'hfedc);
        rd_cmp(OFS_TIMER_LOW, 16'h1234, "timer low");
        rd_cmp(OFS_TIMER_HIGH, 16'hfedc, "timer high");
        reg_wr(OFS_COMMAND, 16'h0000);
        #1 cmp("soft_reset off", 16'h0000, {15'h0, soft_reset});
    endtask
    // builds n descriptors and the mask at start, loads them, then reads the table back in soft reset
    task automatic t_load(input bit wide, input logic [15:0] start, input int n, input logic [15:0] mask,
                          input logic [3:0] dly);
        logic [15:0] step;
        logic [15:0] p;
        logic [15:0] e;
        logic [15:0] v;
        bit          ok;
        step = wide ? STEP_WIDE : STEP_NARROW;
        p = start;
        for (int i = 0; i < n; i++) begin
            e = 16'(i * 5 + 2 + int'(wide));
            for (int k = 0; k < 4; k++) begin
                mem_u.put(p[7:0], k == 0 ? e : slice(e, k));
                p = p + step;
            end
        end
        mem_u.put(p[7:0], mask);
        delay <= dly;
        reg_wr(OFS_RES_UPPER, 16'h00c3);
        reg_wr(OFS_DATA_CFG, {10'h0, wide, 5'h0});
        reg_wr(OFS_DESC_COUNT, 16'hffe0 | 16'(n));
        reg_wr(OFS_DESC_PTR, start);
        frame_active <= 1'b1;
        reg_wr(OFS_COMMAND, 16'h0200);
        ok = 1'b1;
        repeat (10) begin
            @(negedge mclk);
            if (mem_req !== 1'b0) ok = 1'b0;
        end
        @(posedge mclk);
        cmp("fetch held", 16'h0001, {15'h0, ok});
        frame_active <= 1'b0;
        ok = 1'b0;
        for (int w = 0; w < 200 && !ok; w++) begin
            reg_rd(OFS_COMMAND, v);
            ok = (v[CMD_LOAD_FILTER_BIT] === 1'b0);
        end
        if (!ok) begin
            fail_count++;
            test_done();
        end
        rd_cmp(OFS_INT_STATUS, 16'h1000, "done flag");
        rd_cmp(OFS_DESC_PTR, p + step, "pointer");
        rd_cmp(OFS_DESC_COUNT, 16'h0000, "count");
        rd_cmp(OFS_ENTRY_EN, mask, "entry enable");
        reg_wr(OFS_INT_STATUS, 16'h1000);
        rd_cmp(OFS_INT_STATUS, 16'h0000, "done cleared");
        rd_cmp(OFS_PORT_HIGH, 16'h0000, "port out of reset");
        reg_wr(OFS_COMMAND, 16'h0080);
        for (int i = 0; i < n; i++) begin
            e = 16'(i * 5 + 2 + int'(wide));
            reg_wr(OFS_ENTRY_SEL, e);
            for (int k = 1; k < 4; k++) begin
                rd_cmp(6'(OFS_ENTRY_EN - 6'(k)), slice(e, k), "filter port");
            end
        end
        if (n > 0) begin
            reg_wr(OFS_PORT_LOW, 16'hffff);
            rd_cmp(OFS_PORT_LOW, slice(e, 1), "port read-only");
        end
        reg_wr(OFS_COMMAND, 16'h0000);
    endtask

    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_duplex();
        t_load(1'b0, 16'h0040, 2, 16'h0084, 4'h0);
        t_load(1'b1, 16'h0080, 1, 16'h0008, 4'h3);
        t_load(1'b0, 16'h00a0, 0, 16'h0f0f, 4'h1);
        test_done();
    end
endmodule // nic_register_map_cam_loader_bench
